/* File: rtl/pcpm_map.svh */
`ifndef PCPM_MAP_SVH
`define PCPM_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define PCPM_EXT1         8'h00
`define PCPM_MISC3        8'h04
`define PCPM_IRQ_STAT     8'h08
`define PCPM_IRQ_CLR      8'h0c
`define PCPM_IRQ_EN       8'h10
`define PCPM_PINS         8'h14
`define PCPM_SOCK_BASE    8'h20
`define PCPM_SOCK_STRIDE  8'h10
`define PCPM_SUB_MODE     8'h00
`define PCPM_SUB_INTGEN   8'h04
`define PCPM_SUB_MISC1    8'h08
`define PCPM_SUB_ATA      8'h0c

// ****************************************
// Field positions
// ****************************************
`define PCPM_RING_BIT     7
`define PCPM_AUDIO_BIT    4
`define PCPM_LAMP_BIT     2
`define PCPM_ATA_LED_BIT  1
`define PCPM_SLEEP_BIT    4
`define PCPM_SMB_BIT      5
`define PCPM_STRAP_AUDIO  0
`define PCPM_STRAP_LAMP   1
`define PCPM_STRAP_STROBE 2
`define PCPM_STRAP_SERIAL 3
`define PCPM_VS1_WR_BIT   2
`define PCPM_VS2_WR_BIT   3
`define PCPM_VS_PULL_BIT  4
`define PCPM_MODE_WMASK   8'h1f
`define PCPM_MISC3_WMASK  8'hf0

// ****************************************
// Reset values
// ****************************************
`define PCPM_REG_RESET    8'h00

`endif

/* File: rtl/pcpm_pkg.sv */
package pcpm_pkg;

	// ****************************************
	// Card interface modes and socket pin roles
	// ****************************************
	typedef enum logic [1:0] {
		MODE_MEMORY,
		MODE_IO,
		MODE_CARDBUS
	} pcpm_mode_type;

	typedef enum logic [1:0] {
		ROLE_BATTERY_DEAD,
		ROLE_STATUS_CHANGE,
		ROLE_PHONE_WAKE,
		ROLE_CARDBUS_ALERT
	} pcpm_role_type;

endpackage

/* File: rtl/pcpm_sync.sv */
module pcpm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	// ****************************************
	// Two-stage synchroniser
	// ****************************************
	// No reset here on purpose: straps must be tracked while reset is held.
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

/* File: rtl/pcpm_top.sv */
`include "pcpm_map.svh"

// Notes on behaviour
// - Memory mode: status pin means battery dead.
// - I/O mode: status pin means status change.
// - Ring enable bit makes it wake input, except in CardBus mode.
// - Sense pins pulled only by write and pull bits.
// - Audio routed only when socket audio bit set.
// - Audio pin strapped into misc3 bit 0.
// - Lamp driven only with extension bit 2.
// - Disk activity only with ATA bit 1.
// - Sleep bit turns lamp pin into input.
// - Lamp pin strapped into misc3 bit 1.
// - Serial line plain output, or open-drain SMBus.
// - Serial line strapped into misc3 bit 3.
// - Strobe pin strapped into misc3 bit 2.
// - Warning pin carries audio or drive LED.
module pcpm_top #(
	parameter int NSOCK = 2
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic [3:0]       wb_sel_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  irq_o,
	input  wire logic [NSOCK-1:0] battery_dead_status_i,
	input  wire logic [NSOCK-1:0] battery_warning_status_i,
	input  wire logic [NSOCK-1:0] voltage_sense_one_i,
	output logic      [NSOCK-1:0] voltage_sense_one_o,
	output logic      [NSOCK-1:0] voltage_sense_one_oe_o,
	input  wire logic [NSOCK-1:0] voltage_sense_two_i,
	output logic      [NSOCK-1:0] voltage_sense_two_o,
	output logic      [NSOCK-1:0] voltage_sense_two_oe_o,
	input  wire logic             audio_tone_i,
	output logic                  audio_tone_o,
	output logic                  audio_tone_oe_o,
	input  wire logic             activity_lamp_i,
	output logic                  activity_lamp_o,
	output logic                  activity_lamp_oe_o,
	input  wire logic             serial_ref_clock_i,
	input  wire logic             power_switch_serial_line_i,
	output logic                  power_switch_serial_line_o,
	output logic                  power_switch_serial_line_oe_o,
	input  wire logic             power_switch_strobe_i,
	output logic                  power_switch_strobe_o,
	output logic                  power_switch_strobe_oe_o,
	input  wire logic             switch_data_i,
	input  wire logic             switch_strobe_i
);

	localparam int IW = NSOCK + 2;
	localparam int RING_IRQ = NSOCK;
	localparam int SLEEP_IRQ = NSOCK + 1;

	typedef struct packed {
		logic                  ack;
		logic [31:0]           rdat;
		logic                  done;
		logic [3:0]            strap;
		logic [7:0]            ext1;
		logic [7:0]            misc3;
		logic [NSOCK-1:0][7:0] mode;
		logic [NSOCK-1:0][7:0] intgen;
		logic [NSOCK-1:0][7:0] misc1;
		logic [NSOCK-1:0][7:0] ata;
		logic [IW-1:0]         irq_st;
		logic [IW-1:0]         irq_en;
		logic                  irq;
		logic [NSOCK-1:0]      prev_stat;
		logic                  prev_sleep;
		logic                  audio;
		logic                  audio_oe;
		logic                  lamp;
		logic                  lamp_oe;
		logic                  power_switch_serial_line;
		logic                  power_switch_serial_line_oe;
		logic                  strobe;
		logic                  strobe_oe;
		logic [NSOCK-1:0]      vs1_oe;
		logic [NSOCK-1:0]      vs2_oe;
	} pcpm_state_type;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic pcpm_pkg::pcpm_mode_type mode_of(input logic [1:0] f);
		case (f)
			2'b00:   mode_of = pcpm_pkg::MODE_MEMORY;
			2'b01:   mode_of = pcpm_pkg::MODE_IO;
			default: mode_of = pcpm_pkg::MODE_CARDBUS;
		endcase
	endfunction

	function automatic pcpm_pkg::pcpm_role_type role_of(input logic [1:0] f, input logic ring);
		pcpm_pkg::pcpm_mode_type m;
		m = mode_of(f);
		if (m == pcpm_pkg::MODE_CARDBUS) begin
			role_of = pcpm_pkg::ROLE_CARDBUS_ALERT;
		end else if (ring) begin
			role_of = pcpm_pkg::ROLE_PHONE_WAKE;
		end else if (m == pcpm_pkg::MODE_IO) begin
			role_of = pcpm_pkg::ROLE_STATUS_CHANGE;
		end else begin
			role_of = pcpm_pkg::ROLE_BATTERY_DEAD;
		end
	endfunction

	function automatic logic sock_hit(input logic [7:0] adr, input int k, input logic [7:0] sub);
		sock_hit = adr == (`PCPM_SOCK_BASE + 8'(k) * `PCPM_SOCK_STRIDE + sub);
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [NSOCK-1:0] stat_sy;
	logic [NSOCK-1:0] warn_sy;
	logic [NSOCK-1:0] vs1_sy;
	logic [NSOCK-1:0] vs2_sy;
	logic [4:0]       glob_sy;
	logic             audio_sy;
	logic             lamp_sy;
	logic             power_switch_serial_line_sy;
	logic             strobe_sy;
	logic             sclk_sy;

	genvar g;
	generate
		for (g = 0; g < NSOCK; g++) begin : g_sock_sync
			pcpm_sync #(.W(4)) u_sync (
				.clk_i (clk_i),
				.ce_i  (ce_i),
				.d_i   ({battery_dead_status_i[g], battery_warning_status_i[g],
				          voltage_sense_one_i[g], voltage_sense_two_i[g]}),
				.q_o   ({stat_sy[g], warn_sy[g], vs1_sy[g], vs2_sy[g]})
			);
		end
	endgenerate

	pcpm_sync #(.W(5)) u_glob_sync (
		.clk_i (clk_i),
		.ce_i  (ce_i),
		.d_i   ({audio_tone_i, activity_lamp_i, power_switch_serial_line_i,
		          power_switch_strobe_i, serial_ref_clock_i}),
		.q_o   (glob_sy)
	);

	assign audio_sy  = glob_sy[4];
	assign lamp_sy   = glob_sy[3];
	assign power_switch_serial_line_sy  = glob_sy[2];
	assign strobe_sy = glob_sy[1];
	// The reference clock is only observed; it is far slower than clk_i.
	assign sclk_sy   = glob_sy[0];

	// ****************************************
	// Next state
	// ****************************************
	pcpm_state_type s;
	pcpm_state_type next_s;
	logic           wb_req;
	logic           smb;
	logic           sleep_mode;
	logic           ring_ev;
	logic           sleep_ev;
	logic [IW-1:0]  irq_set;
	logic [IW-1:0]  irq_clr;
	logic [7:0]     rd;
	logic           audio_any;
	logic           lamp_any;

	assign wb_req     = wb_cyc_i & wb_stb_i & ~s.ack;
	assign smb        = s.misc3[`PCPM_SMB_BIT];
	assign sleep_mode = s.misc3[`PCPM_SLEEP_BIT];

	always_comb begin
		next_s    = s;
		irq_set   = '0;
		irq_clr   = '0;
		ring_ev   = 1'b0;
		rd        = 8'h00;
		audio_any = 1'b0;
		lamp_any  = 1'b0;

		// Straps are caught once, on the first enabled edge after release.
		if (!s.done) begin
			next_s.done                     = 1'b1;
			next_s.strap[`PCPM_STRAP_AUDIO]  = audio_sy;
			next_s.strap[`PCPM_STRAP_LAMP]   = lamp_sy;
			next_s.strap[`PCPM_STRAP_STROBE] = strobe_sy;
			next_s.strap[`PCPM_STRAP_SERIAL] = power_switch_serial_line_sy;
		end

		// All socket status roles are active low, so a falling edge is the event.
		for (int k = 0; k < NSOCK; k++) begin
			if (s.done && s.prev_stat[k] && !stat_sy[k]) begin
				if (role_of(s.mode[k][1:0], s.intgen[k][`PCPM_RING_BIT]) ==
				    pcpm_pkg::ROLE_PHONE_WAKE) begin
					ring_ev = 1'b1;
				end else begin
					irq_set[k] = 1'b1;
				end
			end
			if (mode_of(s.mode[k][1:0]) != pcpm_pkg::MODE_MEMORY) begin
				audio_any = audio_any | (s.misc1[k][`PCPM_AUDIO_BIT] & warn_sy[k]);
				lamp_any  = lamp_any | (s.ata[k][`PCPM_ATA_LED_BIT] & ~warn_sy[k]);
			end
			next_s.vs1_oe[k] = next_s.done & s.mode[k][`PCPM_VS_PULL_BIT] &
			                   s.mode[k][`PCPM_VS1_WR_BIT];
			next_s.vs2_oe[k] = next_s.done & s.mode[k][`PCPM_VS_PULL_BIT] &
			                   s.mode[k][`PCPM_VS2_WR_BIT];
		end
		next_s.prev_stat  = stat_sy;
		next_s.prev_sleep = lamp_sy;
		sleep_ev          = s.done & sleep_mode & s.prev_sleep & ~lamp_sy;
		irq_set[RING_IRQ]  = ring_ev;
		irq_set[SLEEP_IRQ] = sleep_ev;

		// Pin drivers; every enable stays low until the straps are latched.
		next_s.audio     = audio_any;
		next_s.audio_oe  = next_s.done;
		next_s.lamp      = s.ext1[`PCPM_LAMP_BIT] & lamp_any;
		next_s.lamp_oe   = next_s.done & ~sleep_mode;
		if (smb) begin
			next_s.power_switch_serial_line     = 1'b0;
			next_s.power_switch_serial_line_oe  = next_s.done & ~switch_data_i;
			next_s.strobe    = 1'b0;
			next_s.strobe_oe = next_s.done & ~switch_strobe_i;
		end else begin
			next_s.power_switch_serial_line     = switch_data_i;
			next_s.power_switch_serial_line_oe  = next_s.done;
			next_s.strobe    = switch_strobe_i;
			next_s.strobe_oe = next_s.done;
		end

		// Register bus: one wait state, answer registered with ack.
		next_s.ack = wb_req;
		if (wb_req) begin
			case (wb_adr_i)
				`PCPM_EXT1:     rd = s.ext1;
				`PCPM_MISC3:    rd = {s.misc3[7:4], s.strap};
				`PCPM_IRQ_STAT: rd = 8'(s.irq_st);
				`PCPM_IRQ_EN:   rd = 8'(s.irq_en);
				`PCPM_PINS:     rd = {3'h0, strobe_sy, power_switch_serial_line_sy, audio_sy, lamp_sy, sclk_sy};
				default:        rd = 8'h00;
			endcase
			for (int k = 0; k < NSOCK; k++) begin
				if (sock_hit(wb_adr_i, k, `PCPM_SUB_MODE)) begin
					rd = {vs2_sy[k], vs1_sy[k], stat_sy[k], s.mode[k][4:0]};
				end
				if (sock_hit(wb_adr_i, k, `PCPM_SUB_INTGEN)) begin
					rd = s.intgen[k];
				end
				if (sock_hit(wb_adr_i, k, `PCPM_SUB_MISC1)) begin
					rd = s.misc1[k];
				end
				if (sock_hit(wb_adr_i, k, `PCPM_SUB_ATA)) begin
					rd = s.ata[k];
				end
			end
			if (wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i)
					`PCPM_EXT1:    next_s.ext1 = wb_dat_i[7:0];
					`PCPM_MISC3:   next_s.misc3 = wb_dat_i[7:0] & `PCPM_MISC3_WMASK;
					`PCPM_IRQ_CLR: irq_clr = wb_dat_i[IW-1:0];
					`PCPM_IRQ_EN:  next_s.irq_en = wb_dat_i[IW-1:0];
					default:       next_s.ext1 = s.ext1;
				endcase
				for (int k = 0; k < NSOCK; k++) begin
					if (sock_hit(wb_adr_i, k, `PCPM_SUB_MODE)) begin
						next_s.mode[k] = wb_dat_i[7:0] & `PCPM_MODE_WMASK;
					end
					if (sock_hit(wb_adr_i, k, `PCPM_SUB_INTGEN)) begin
						next_s.intgen[k] = wb_dat_i[7:0];
					end
					if (sock_hit(wb_adr_i, k, `PCPM_SUB_MISC1)) begin
						next_s.misc1[k] = wb_dat_i[7:0];
					end
					if (sock_hit(wb_adr_i, k, `PCPM_SUB_ATA)) begin
						next_s.ata[k] = wb_dat_i[7:0];
					end
				end
			end
		end
		next_s.rdat = {24'h000000, rd};

		// A new event beats a clear written in the same cycle.
		next_s.irq_st = (s.irq_st & ~irq_clr) | irq_set;
		next_s.irq    = |(next_s.irq_st & next_s.irq_en);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign wb_ack_o                      = s.ack;
	assign wb_dat_o                      = s.rdat;
	assign irq_o                         = s.irq;
	assign audio_tone_o                  = s.audio;
	assign audio_tone_oe_o               = s.audio_oe;
	assign activity_lamp_o               = s.lamp;
	assign activity_lamp_oe_o            = s.lamp_oe;
	assign power_switch_serial_line_o    = s.power_switch_serial_line;
	assign power_switch_serial_line_oe_o = s.power_switch_serial_line_oe;
	assign power_switch_strobe_o         = s.strobe;
	assign power_switch_strobe_oe_o      = s.strobe_oe;
	assign voltage_sense_one_o           = {NSOCK{s.done}};
	assign voltage_sense_two_o           = {NSOCK{s.done}};
	assign voltage_sense_one_oe_o        = s.vs1_oe;
	assign voltage_sense_two_oe_o        = s.vs2_oe;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence strap_release;
		$past(ce_i) && !$past(s.done) && s.done;
	endsequence

	sequence ring_fall;
		ce_i && ring_ev;
	endsequence

	chk_strap_audio:  assert property (strap_release |-> s.strap[0] == $past(audio_sy))
		else $error("audio strap not latched");
	chk_strap_lamp:   assert property (strap_release |-> s.strap[1] == $past(lamp_sy))
		else $error("lamp strap not latched");
	chk_strap_strobe: assert property (strap_release |-> s.strap[2] == $past(strobe_sy))
		else $error("strobe strap not latched");
	chk_strap_serial: assert property (strap_release |-> s.strap[3] == $past(power_switch_serial_line_sy))
		else $error("serial strap not latched");
	chk_strap_hold:   assert property (s.done |=> s.done && $stable(s.strap))
		else $error("straps changed after latch");
	chk_pins_released: assert property (!s.done |-> !(s.audio_oe | s.lamp_oe | s.power_switch_serial_line_oe |
		s.strobe_oe | (|s.vs1_oe)))
		else $error("pin driven before straps latched");
	chk_audio_gate:   assert property ($past(ce_i) && s.audio |->
		$past(s.misc1[0][`PCPM_AUDIO_BIT] | s.misc1[NSOCK-1][`PCPM_AUDIO_BIT]))
		else $error("audio routed while disabled");
	chk_lamp_gate:    assert property ($past(ce_i) && s.lamp |->
		$past(s.ext1[`PCPM_LAMP_BIT]) && $past(|s.ata))
		else $error("lamp driven while disabled");
	chk_sleep_input:  assert property ($past(ce_i) && $past(sleep_mode) |-> !s.lamp_oe)
		else $error("lamp pin driven in sleep mode");
	chk_smb_open:     assert property ($past(ce_i) && $past(smb) |-> !s.power_switch_serial_line)
		else $error("serial line driven high in SMBus mode");
	chk_vs_pull:      assert property (s.vs1_oe[0] |-> $past(s.mode[0][`PCPM_VS_PULL_BIT]))
		else $error("sense pin pulled without control");
	chk_ring_event:   assert property (ring_fall |=> s.irq_st[RING_IRQ] && s.done)
		else $error("ring event not recorded");

endmodule

/* File: verif/pcpm_card_model.sv */
module pcpm_card_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] pull_i,
	input  wire logic [3:0] pin_o_i,
	input  wire logic [3:0] pin_oe_i,
	input  wire logic [3:0] vs_o_i,
	input  wire logic [3:0] vs_oe_i,
	input  wire logic [1:0] dead_i,
	input  wire logic [1:0] warn_i,
	output logic      [3:0] pin_o,
	output logic      [3:0] vs_o,
	output logic      [1:0] dead_o,
	output logic      [1:0] warn_o,
	output logic            refclk_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Card, switch and board pins
	// ****************************************
	logic       float_level = 1'b0;
	logic       ref_level   = 1'b0;
	logic [8:0] ref_cnt     = 9'h000;

	// A released sense pin has no pull, so it shows a level that changes every cycle.
	always @(posedge clk_i) begin
		float_level <= ~float_level;
		ref_cnt     <= (ref_cnt == 9'h137) ? 9'h000 : ref_cnt + 9'h001;
		if (ref_cnt == 9'h137) begin
			ref_level <= ~ref_level;
		end
	end

	assign refclk_o = ref_level;
	assign pin_o    = (pin_oe_i & pin_o_i) | (~pin_oe_i & pull_i);
	assign vs_o     = (vs_oe_i & vs_o_i) | (~vs_oe_i & {4{float_level}});
	assign dead_o   = dead_i;
	assign warn_o   = warn_i;
endmodule

/* File: verif/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_i           = 1'b0;
	logic        rst_i           = 1'b1;
	logic        ce_i            = 1'b1;
	logic        wb_cyc_i        = 1'b0;
	logic        wb_stb_i        = 1'b0;
	logic        wb_we_i         = 1'b0;
	logic [7:0]  wb_adr_i        = 8'h00;
	logic [31:0] wb_dat_i        = 32'h0;
	logic [3:0]  wb_sel_i        = 4'h0;
	logic        switch_data_i   = 1'b0;
	logic        switch_strobe_i = 1'b0;
	logic [3:0]  pull            = 4'h0;
	logic [1:0]  dead            = 2'h3;
	logic [1:0]  warn            = 2'h0;
	logic [1:0]  s;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        irq_o;
	logic [1:0]  bds;
	logic [1:0]  bws;
	wire  [1:0]  vs1_i, vs1_o, vs1_oe, vs2_i, vs2_o, vs2_oe;
	wire  [3:0]  pin_w, pin_o, pin_oe;
	logic        refclk;
	logic [31:0] exp_q[$];
	logic [31:0] mask_q[$];
	int          fails      = 0;
	int          num_checks = 0;
	int          cycles     = 0;

	pcpm_top i_pcpm_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.irq_o(irq_o), .battery_dead_status_i(bds), .battery_warning_status_i(bws),
		.voltage_sense_one_i(vs1_i), .voltage_sense_one_o(vs1_o),
		.voltage_sense_one_oe_o(vs1_oe), .voltage_sense_two_i(vs2_i),
		.voltage_sense_two_o(vs2_o), .voltage_sense_two_oe_o(vs2_oe),
		.audio_tone_i(pin_w[0]), .audio_tone_o(pin_o[0]), .audio_tone_oe_o(pin_oe[0]),
		.activity_lamp_i(pin_w[1]), .activity_lamp_o(pin_o[1]),
		.activity_lamp_oe_o(pin_oe[1]), .serial_ref_clock_i(refclk),
		.power_switch_serial_line_i(pin_w[3]), .power_switch_serial_line_o(pin_o[3]),
		.power_switch_serial_line_oe_o(pin_oe[3]), .power_switch_strobe_i(pin_w[2]),
		.power_switch_strobe_o(pin_o[2]), .power_switch_strobe_oe_o(pin_oe[2]),
		.switch_data_i(switch_data_i), .switch_strobe_i(switch_strobe_i));

	pcpm_card_model i_pcpm_card_model (.clk_i(clk_i), .pull_i(pull), .pin_o_i(pin_o),
		.pin_oe_i(pin_oe), .vs_o_i({vs2_o, vs1_o}), .vs_oe_i({vs2_oe, vs1_oe}),
		.dead_i(dead), .warn_i(warn), .pin_o(pin_w), .vs_o({vs2_i, vs1_i}),
		.dead_o(bds), .warn_o(bws), .refclk_o(refclk));

	// ****************************************
	// Bus, checking and closing tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Only the global cycle ceiling ends a wait for the answer.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// The socket's status pin falls once; the sticky bit is read while the pin is low, then cleared after its rise.
	task automatic status_event(input logic k, input logic [7:0] mode, input logic [7:0] ring,
			input logic [7:0] en, input logic [7:0] bitv);
		wr(8'h10, en);
		wr(k ? 8'h30 : 8'h20, mode);
		wr(k ? 8'h34 : 8'h24, ring);
		wr(8'h0c, 8'hff);
		dead[k] <= 1'b0;
		idle(8);
		rd(8'h08, {24'h0, bitv}, 32'hff);
		check({31'h0, irq_o}, {31'h0, |(en & bitv)});
		dead[k] <= 1'b1;
		idle(8);
		wr(8'h0c, 8'hff);
		rd(8'h08, 32'h0, 32'hff);
	endtask

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
			check(wb_dat_o & mask_q.pop_front(), exp_q.pop_front());
		end
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(32'h6e53d7aa));
		pull = 4'($urandom());
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, {28'h0, pull}, 32'hff);
		rd(8'h00, 32'h0, 32'hffffffff);
		wr(8'h04, 8'h0f);
		rd(8'h04, {28'h0, pull}, 32'hff);
		rd(8'hfc, 32'h0, 32'hffffffff);
		$display("test straps done");
		wr(8'h20, 8'h01);
		for (int i = 0; i < 4; i++) begin
			warn[0] <= i[0];
			wr(8'h28, {3'h0, i[1], 4'h0});
			idle(6);
			rd(8'h14, {29'h0, i[0] & i[1], 2'h0}, 32'h4);
		end
		wr(8'h20, 8'h00);
		idle(6);
		rd(8'h14, 32'h0, 32'h4);
		$display("test audio done");
		wr(8'h28, 8'h00);
		wr(8'h20, 8'h01);
		for (int i = 0; i < 5; i++) begin
			warn[0] <= (i == 4);
			wr(8'h00, {5'h0, i[0] | i[2], 2'h0});
			wr(8'h2c, {6'h0, i[1] | i[2], 1'h0});
			idle(6);
			rd(8'h14, {30'h0, i[0] & i[1], 1'h0}, 32'h2);
		end
		warn[0] <= 1'b0;
		pull[1] <= 1'b1;
		wr(8'h10, 8'hff);
		wr(8'h04, 8'h10);
		wr(8'h0c, 8'hff);
		pull[1] <= 1'b0;
		idle(8);
		rd(8'h14, 32'h0, 32'h2);
		rd(8'h08, 32'h8, 32'hff);
		check({31'h0, irq_o}, 32'h1);
		wr(8'h04, 8'h00);
		pull[1] <= 1'b1;
		$display("test lamp done");
		status_event(1'b1, 8'h00, 8'h00, 8'hff, 8'h02);
		status_event(1'b0, 8'h01, 8'h00, 8'hff, 8'h01);
		status_event(1'b0, 8'h01, 8'h80, 8'hff, 8'h04);
		status_event(1'b1, 8'h02, 8'h00, 8'h00, 8'h02);
		$display("test status done");
		for (int c = 0; c < 8; c++) begin
			wr(8'h20, {3'h0, c[2:0], 2'h1});
			idle(3);
			check({vs2_oe[0], vs1_oe[0]}, {c[2] & c[1], c[2] & c[0]});
			// A released sense pin floats, so only pulled pins are compared.
			if (c[2]) begin
				rd(8'h20, {24'h0, c[1], c[0], 1'b1, c[2:0], 2'h1}, {24'h0, c[1], c[0], 6'h3f});
			end
		end
		$display("test sense done");
		pull[3:2] <= 2'h3;
		for (int i = 0; i < 8; i++) begin
			s = 2'($urandom());
			wr(8'h04, {2'h0, i[2], 5'h0});
			switch_data_i   <= s[1];
			switch_strobe_i <= s[0];
			idle(3);
			check({pin_oe[3:2], pin_o[3:2]}, i[2] ? {~s, 2'h0} : {2'h3, s});
			rd(8'h14, {27'h0, s[0], s[1], 3'h0}, 32'h18);
		end
		// The last pass leaves SMBus mode on; a low enable must freeze the pin.
		ce_i          <= 1'b0;
		switch_data_i <= ~s[1];
		idle(4);
		check({31'h0, pin_oe[3]}, {31'h0, ~s[1]});
		ce_i <= 1'b1;
		idle(3);
		check({31'h0, pin_oe[3]}, {31'h0, s[1]});
		$display("test switch done");
		end_of_test();
	end
endmodule
